// ===== verilog/fcp_pkg.sv
// Package for the flash configuration and protection register block.
// Assumes an APB slave with 32-bit data and byte addressing.
package fcp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  // Register indexes; each register is one aligned word at four times its index.
  localparam logic [7:0] IRQ_KEY_IDX = 8'h03;
  localparam logic [7:0] PROT_IDX = 8'h04;
  localparam logic [7:0] IRQ_KEY_OFS = 8'h0C;
  localparam logic [7:0] PROT_OFS = 8'h10;
  localparam logic [7:0] OP_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h24;
  localparam logic [7:0] FLAGS_OFS = 8'h28;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BE_IE_BIT = 7;
  localparam int CC_IE_BIT = 6;
  localparam int KEY_ACCESS_BIT = 5;
  localparam int POPEN_BIT = 7;
  localparam int SPARE_BIT = 6;
  localparam int HDIS_BIT = 5;
  localparam int HS_LSB = 3;
  localparam int LDIS_BIT = 2;
  localparam int LS_LSB = 0;
  localparam int OP_START_BIT = 31;
  localparam int OP_MASS_BIT = 30;
  localparam int OP_WIDE_BIT = 29;
  localparam logic [7:0] IRQ_KEY_MASK = 8'hE0;
  localparam logic [7:0] IRQ_KEY_RESET = 8'h00;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [15:0] PROT_NV_ADDR = 16'hFF0D;
  localparam logic [1:0] KEY_ENABLED = 2'h2;
  // ----------------------------------------
  // Range bounds
  // ----------------------------------------
  localparam logic [15:0] LOW_BASE = 16'h4000;
  localparam logic [15:0] HIGH_TOP = 16'hFFFF;
endpackage

// ===== verilog/fcp_regs.sv
// Flash configuration and protection registers with range checking.
// Assumes an APB master, a flash array reader at reset and a command engine.
// How it works
// - Config byte holds buffer-empty IE bit 7, complete IE bit 6, key access bit 5.
// - Key access bit is writable only while backdoor key field is enabled.
// - Backdoor key field counts as enabled only for pattern 10.
// - Buffer-empty enable gates buffer-empty flag onto its interrupt request.
// - Complete enable gates command-complete flag onto its interrupt request.
// - Key access routes array writes to backdoor keys and invalidates reads.
// - Protection byte at offset 0x10 reads in every mode.
// - Protection-open bit may go from 1 to 0 only; the table refuses every such step, so no write clears it.
// - Low size field writable only while low disable is set.
// - High size field writable only while high disable is set.
// - Protection byte loads from nonvolatile byte 0xFF0D during reset.
// - Program or erase into protected range is refused and flags violation.
// - Mass erase allowed only with open, low and high disable all set.
// - Open polarity chooses protected or unprotected meaning of ranges.
// - High disable bit 5 enables high range when 0.
// - Low disable bit 2 enables low range when 0.
// - High size picks 2K, 4K, 8K or 16K ending at top.
// - Low size picks 1K, 2K, 4K or 8K from 0x4000.
// - Writes giving a disallowed scenario are ignored; protection only grows.
`timescale 1ns/10ps
module fcp_regs
  import fcp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Reset-time load of nonvolatile bytes
  input wire logic nv_load_i,
  input wire logic [7:0] nv_prot_byte_i,
  input wire logic [1:0] backdoor_key_enable_i,
  // Command engine flags
  input wire logic buffer_empty_flag_i,
  input wire logic cmd_complete_flag_i,
  // Flash array access routing
  input wire logic array_wr_i,
  input wire logic array_rd_i,
  output logic nv_addr_o,
  output logic cmd_seq_wr_o,
  output logic key_wr_o,
  output logic rd_invalid_o,
  // Interrupts and protection results
  output logic buffer_empty_irq_o,
  output logic cmd_complete_irq_o,
  output logic op_refused_o,
  output logic op_granted_o,
  output logic protection_violation_flag_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Low range end address for a size code.
  function automatic logic [15:0] low_end(input logic [1:0] sz);
    low_end = LOW_BASE + ((16'h0400 << sz) - 16'h0001);
  endfunction

  // High range start address for a size code.
  function automatic logic [15:0] high_start(input logic [1:0] sz);
    high_start = HIGH_TOP - ((16'h0800 << sz) - 16'h0001);
  endfunction

  // The three control bits of the protection byte select one of eight
  // scenarios. Scenario 0 leaves the whole array writable, scenario 7
  // leaves only the two enabled ranges writable while the rest is locked.
  // The numbering matters because the transition table below is indexed
  // by it; the size fields play no part in the scenario number.
  // Scenario number: open, high disable, low disable as in the function table.
  function automatic logic [2:0] scen(input logic [7:0] p);
    logic [2:0] s;
    s = 3'h0;
    case ({p[POPEN_BIT], p[HDIS_BIT], p[LDIS_BIT]})
      3'b111: s = 3'h0;
      3'b110: s = 3'h1;
      3'b101: s = 3'h2;
      3'b100: s = 3'h3;
      3'b011: s = 3'h4;
      3'b001: s = 3'h5;
      3'b010: s = 3'h6;
      3'b000: s = 3'h7;
      default: s = 3'h0;
    endcase
    scen = s;
  endfunction

  // Each row is a bit mask of the target scenarios that may follow the
  // source scenario. Every allowed step adds protection or keeps it; a
  // step that would open a locked range has its bit clear, so the write
  // that asks for it is dropped as a whole.
  // Allowed transition table, one row per source scenario.
  function automatic logic allowed(input logic [2:0] from, input logic [2:0] to);
    logic [7:0] row;
    row = 8'h00;
    case (from)
      3'h0: row = 8'h0F;
      3'h1: row = 8'h0A;
      3'h2: row = 8'h0C;
      3'h3: row = 8'h08;
      3'h4: row = 8'h18;
      3'h5: row = 8'h3C;
      3'h6: row = 8'h5A;
      3'h7: row = 8'hFF;
      default: row = 8'h00;
    endcase
    allowed = row[to];
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] irq_key_cfg;
  logic [7:0] prot;
  logic [15:0] op_addr;
  logic op_mass;
  logic op_wide;
  logic op_pending;
  logic [1:0] key_en_q1;
  logic [1:0] key_en_q2;
  logic [7:0] next_prot;
  logic key_enabled;
  logic wr_acc;
  logic rd_acc;
  logic in_low;
  logic in_high;
  logic hit_prot;
  logic low_hit;
  logic high_hit;
  logic setup_ph;
  logic wr_irq_key;
  logic wr_prot;
  logic wr_op;
  logic wr_flags;
  logic prot_step_ok;
  logic mass_ok;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // The setup phase is where the read answer is prepared, so that the
  // data stands during the single access cycle that ends the transfer.
  assign setup_ph = psel_i && !penable_i;

  // Writes take effect only at the access edge; a setup phase alone changes only the
  // read data, ready and error registers, never a configuration or protection register.
  assign wr_irq_key = wr_acc && (paddr_i == IRQ_KEY_OFS);
  assign wr_prot = wr_acc && (paddr_i == PROT_OFS);
  assign wr_op = wr_acc && (paddr_i == OP_OFS);
  assign wr_flags = wr_acc && (paddr_i == FLAGS_OFS);

  // A protection write is checked as a whole against the table, so a
  // partly legal value cannot slip through field by field.
  assign prot_step_ok = allowed(scen(prot), scen(next_prot));

  // Mass erase needs all three bits set: open, high disable, low disable.
  assign mass_ok = prot[POPEN_BIT] && prot[HDIS_BIT] && prot[LDIS_BIT];

  // Backdoor key field is static after reset but still crosses in from a strap.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      key_en_q1 <= 2'h0;
      key_en_q2 <= 2'h0;
    end else begin
      key_en_q1 <= backdoor_key_enable_i;
      key_en_q2 <= key_en_q1;
    end
  end

  assign key_enabled = (key_en_q2 == KEY_ENABLED);
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_key_cfg <= IRQ_KEY_RESET;
    end else if (wr_irq_key) begin
      irq_key_cfg[BE_IE_BIT] <= pwdata_i[BE_IE_BIT];
      irq_key_cfg[CC_IE_BIT] <= pwdata_i[CC_IE_BIT];
      if (key_enabled) begin
        irq_key_cfg[KEY_ACCESS_BIT] <= pwdata_i[KEY_ACCESS_BIT];
      end
    end
  end

  // Candidate value: open only clears, sizes freeze once their disable is clear.
  always_comb begin
    next_prot = prot;
    next_prot[POPEN_BIT] = prot[POPEN_BIT] & pwdata_i[POPEN_BIT];
    next_prot[HDIS_BIT] = pwdata_i[HDIS_BIT];
    next_prot[LDIS_BIT] = pwdata_i[LDIS_BIT];
    if (prot[HDIS_BIT]) begin
      next_prot[HS_LSB +: 2] = pwdata_i[HS_LSB +: 2];
    end
    if (prot[LDIS_BIT]) begin
      next_prot[LS_LSB +: 2] = pwdata_i[LS_LSB +: 2];
    end
  end

  // Protection byte is taken from the nonvolatile copy while reset loading runs.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prot <= PROT_RESET;
    end else if (nv_load_i) begin
      prot <= nv_prot_byte_i;
    end else if (wr_prot && prot_step_ok) begin
      prot <= next_prot;
    end
  end

  // ----------------------------------------
  // Range check
  // ----------------------------------------
  // The low range always starts at the base of the array and grows up;
  // the high range always ends at the top of the map and grows down.
  // Both checks look at the stored operation address only, so a read of
  // the array never passes through here and is never refused.
  assign in_low = (op_addr >= LOW_BASE) && (op_addr <= low_end(prot[LS_LSB +: 2]));
  assign in_high = (op_addr >= high_start(prot[HS_LSB +: 2]));
  assign low_hit = !prot[LDIS_BIT] && in_low;
  assign high_hit = !prot[HDIS_BIT] && in_high;

  // Open set: enabled ranges are protected; open clear: only enabled ranges are free.
  always_comb begin
    if (prot[POPEN_BIT]) begin
      hit_prot = low_hit || high_hit;
    end else begin
      hit_prot = !(low_hit || high_hit);
    end
  end

  // Software posts a program or erase request; the verdict appears two cycles later.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      op_addr <= 16'h0000;
      op_mass <= 1'b0;
      op_wide <= 1'b0;
      op_pending <= 1'b0;
    end else begin
      op_pending <= wr_op && pwdata_i[OP_START_BIT];
      if (wr_op) begin
        op_addr <= pwdata_i[15:0];
        op_mass <= pwdata_i[OP_MASS_BIT];
        op_wide <= pwdata_i[OP_WIDE_BIT];
      end
    end
  end

  // A wide op is a sector erase treated like a program for checking purposes.
  // A new violation wins over a clear in the same cycle, so software never
  // loses a refusal that happened while it was clearing an older one.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      op_refused_o <= 1'b0;
      op_granted_o <= 1'b0;
      protection_violation_flag_o <= 1'b0;
    end else begin
      op_refused_o <= 1'b0;
      op_granted_o <= 1'b0;
      if (op_pending) begin
        if (op_mass ? !mass_ok : hit_prot) begin
          op_refused_o <= 1'b1;
          protection_violation_flag_o <= 1'b1;
        end else begin
          op_granted_o <= 1'b1;
        end
      end else if (wr_flags && pwdata_i[0]) begin
        protection_violation_flag_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Array routing and interrupts
  // ----------------------------------------
  // Routing follows the key access bit at the time of the array access.
  // The interrupt requests are plain levels; they drop as soon as either
  // the enable or the flag drops, with one cycle of register delay.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cmd_seq_wr_o <= 1'b0;
      key_wr_o <= 1'b0;
      rd_invalid_o <= 1'b0;
      nv_addr_o <= 1'b0;
      buffer_empty_irq_o <= 1'b0;
      cmd_complete_irq_o <= 1'b0;
    end else begin
      cmd_seq_wr_o <= array_wr_i && !irq_key_cfg[KEY_ACCESS_BIT];
      key_wr_o <= array_wr_i && irq_key_cfg[KEY_ACCESS_BIT];
      rd_invalid_o <= array_rd_i && irq_key_cfg[KEY_ACCESS_BIT];
      nv_addr_o <= op_addr == PROT_NV_ADDR;
      buffer_empty_irq_o <= irq_key_cfg[BE_IE_BIT] && buffer_empty_flag_i;
      cmd_complete_irq_o <= irq_key_cfg[CC_IE_BIT] && cmd_complete_flag_i;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // The slave never stretches a transfer: ready rises in every access
  // cycle. Unmapped addresses answer with an error and read as zero.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup_ph;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (setup_ph) begin
        case (paddr_i)
          IRQ_KEY_OFS: prdata_o <= {24'h000000, irq_key_cfg & IRQ_KEY_MASK};
          PROT_OFS: prdata_o <= {24'h000000, prot};
          OP_OFS: prdata_o <= {op_mass, op_wide, 14'h0000, op_addr};
          STATUS_OFS: prdata_o <= {28'h0000000, key_enabled, buffer_empty_flag_i,
                                   cmd_complete_flag_i, irq_key_cfg[KEY_ACCESS_BIT]};
          FLAGS_OFS: prdata_o <= {31'h00000000, protection_violation_flag_o};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_acc;

endmodule

// ===== tb/fcp_regs_chk.sv
// Assertion checker for the flash configuration and protection registers.
// Assumes it is bound to fcp_regs and sees only that module's ports.
`timescale 1ns/10ps
module fcp_regs_chk
  import fcp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic buffer_empty_flag_i,
  input wire logic cmd_complete_flag_i,
  input wire logic array_wr_i,
  input wire logic array_rd_i,
  input wire logic cmd_seq_wr_o,
  input wire logic key_wr_o,
  input wire logic rd_invalid_o,
  input wire logic buffer_empty_irq_o,
  input wire logic cmd_complete_irq_o,
  input wire logic op_refused_o,
  input wire logic op_granted_o,
  input wire logic protection_violation_flag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_op_wr;
    psel_i && penable_i && pwrite_i && pready_o && paddr_i == OP_OFS && pwdata_i[OP_START_BIT];
  endsequence
  sequence s_verdict;
    op_refused_o || op_granted_o;
  endsequence
  a_op_verdict_due: assert property (s_op_wr |-> ##[1:3] s_verdict)
    else $error("op write without verdict");
  a_verdict_pulse: assert property (s_verdict |-> !(op_refused_o && op_granted_o) ##1 !s_verdict)
    else $error("verdict not a single pulse");
  a_refuse_sets_flag: assert property (op_refused_o |-> ##[0:1] protection_violation_flag_o)
    else $error("refusal without violation flag");
  a_flag_clear_cause: assert property ($fell(protection_violation_flag_o) && !$past(srst_i)
    |-> $past(psel_i && penable_i && pwrite_i && paddr_i == FLAGS_OFS && pwdata_i[0]))
    else $error("violation flag dropped without clear");
  a_be_irq_gate: assert property (buffer_empty_irq_o |-> $past(buffer_empty_flag_i))
    else $error("buffer empty irq without flag");
  a_cc_irq_gate: assert property (cmd_complete_irq_o |-> $past(cmd_complete_flag_i))
    else $error("complete irq without flag");
  a_key_route: assert property (key_wr_o |-> $past(array_wr_i) && !cmd_seq_wr_o)
    else $error("key write without array write");
  a_rd_invalid_cause: assert property (rd_invalid_o |-> $past(array_rd_i))
    else $error("invalid read without array read");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i ##1 !pready_o)
    else $error("ready outside a single access cycle");
  a_slverr_ready: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
endmodule
bind fcp_regs fcp_regs_chk u_chk (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .buffer_empty_flag_i, .cmd_complete_flag_i,
  .array_wr_i, .array_rd_i, .cmd_seq_wr_o, .key_wr_o, .rd_invalid_o, .buffer_empty_irq_o,
  .cmd_complete_irq_o, .op_refused_o, .op_granted_o, .protection_violation_flag_o);

// ===== tb/tb_fcp_regs.sv
// Self-checking testbench for the flash configuration and protection registers.
// Assumes fcp_regs with its checker bound; the bench drives every input itself.
`timescale 1ns/10ps
module tb_fcp_regs
  import fcp_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, nv_prot_byte_i = 8'hFF;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, nv_addr_o, cmd_seq_wr_o, key_wr_o, rd_invalid_o, err;
  logic nv_load_i = 1'b0, buffer_empty_flag_i = 1'b0, cmd_complete_flag_i = 1'b0;
  logic array_wr_i = 1'b0, array_rd_i = 1'b0;
  logic [1:0] backdoor_key_enable_i = 2'h0;
  logic buffer_empty_irq_o, cmd_complete_irq_o, op_refused_o, op_granted_o;
  logic protection_violation_flag_o;
  int n_mismatch = 0;
  int check_count = 0;
  logic [1:0] keys [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [15:0] op_addr [5] = '{16'hEFFF, 16'hF000, 16'h4FFF, 16'h5000, 16'hFF0D};
  logic op_ref [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  always #25 core_clk_i = ~core_clk_i;
  fcp_regs dut (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .nv_load_i, .nv_prot_byte_i, .backdoor_key_enable_i,
    .buffer_empty_flag_i, .cmd_complete_flag_i, .array_wr_i, .array_rd_i, .nv_addr_o,
    .cmd_seq_wr_o, .key_wr_o, .rd_invalid_o, .buffer_empty_irq_o, .cmd_complete_irq_o,
    .op_refused_o, .op_granted_o, .protection_violation_flag_o);
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ready is sampled high, as the bus requires.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic op(input logic [15:0] a, input logic mass, input logic refused);
    apb(1'b1, OP_OFS, {1'b1, mass, 14'h0000, a});
    repeat (5) begin
      @(posedge core_clk_i);
      if (op_refused_o === 1'b1 || op_granted_o === 1'b1) break;
    end
    chk({30'h0, op_refused_o, op_granted_o}, {30'h0, refused, ~refused});
  endtask
  task automatic pulse(input logic w, input logic [2:0] exp);
    array_wr_i <= w;
    array_rd_i <= ~w;
    @(posedge core_clk_i);
    array_wr_i <= 1'b0;
    array_rd_i <= 1'b0;
    @(posedge core_clk_i);
    chk({29'h0, cmd_seq_wr_o, key_wr_o, rd_invalid_o}, {29'h0, exp});
  endtask
  task automatic nvload(input logic [7:0] b);
    nv_prot_byte_i <= b;
    nv_load_i <= 1'b1;
    @(posedge core_clk_i);
    nv_load_i <= 1'b0;
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    #150000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rdchk(PROT_OFS, 32'hFF);
    rdchk(IRQ_KEY_OFS, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    foreach (keys[i]) begin
      backdoor_key_enable_i <= keys[i];
      repeat (3) @(posedge core_clk_i);
      apb(1'b1, IRQ_KEY_OFS, 32'hFF);
      rdchk(IRQ_KEY_OFS, (keys[i] == KEY_ENABLED) ? 32'hE0 : 32'hC0);
    end
    rdchk(STATUS_OFS, 32'h9);
    buffer_empty_flag_i <= 1'b1;
    cmd_complete_flag_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk({30'h0, buffer_empty_irq_o, cmd_complete_irq_o}, 32'h3);
    pulse(1'b1, 3'h2);
    pulse(1'b0, 3'h1);
    apb(1'b1, IRQ_KEY_OFS, 32'h0);
    repeat (2) @(posedge core_clk_i);
    chk({30'h0, buffer_empty_irq_o, cmd_complete_irq_o}, 32'h0);
    pulse(1'b1, 3'h4);
    pulse(1'b0, 3'h0);
    apb(1'b1, PROT_OFS, 32'h7F);
    rdchk(PROT_OFS, 32'hFF);
    apb(1'b1, PROT_OFS, 32'hFA);
    rdchk(PROT_OFS, 32'hFA);
    apb(1'b1, PROT_OFS, 32'hF9);
    rdchk(PROT_OFS, 32'hFA);
    apb(1'b1, PROT_OFS, 32'hCA);
    rdchk(PROT_OFS, 32'hCA);
    foreach (op_addr[i]) op(op_addr[i], 1'b0, op_ref[i]);
    chk({31'h0, nv_addr_o}, 32'h1);
    op(16'h8000, 1'b1, 1'b1);
    rdchk(FLAGS_OFS, 32'h1);
    apb(1'b1, FLAGS_OFS, 32'h1);
    rdchk(FLAGS_OFS, 32'h0);
    nvload(8'h7B);
    rdchk(PROT_OFS, 32'h7B);
    apb(1'b1, PROT_OFS, 32'hFB);
    rdchk(PROT_OFS, 32'h7B);
    op(16'h5FFF, 1'b0, 1'b0);
    op(16'h6000, 1'b0, 1'b1);
    nvload(8'hFF);
    op(16'h8000, 1'b1, 1'b0);
    op(16'hFF0D, 1'b0, 1'b0);
    results();
  end
endmodule
